// ===== hw/ibus_pkg.sv
// Shared constants for the serial bus receive and transmit unit
package ibus_pkg;

    // ----------------------------------------------------------------
    // Register addresses (4-bit latched address)
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_STATUS_0 = 4'h0;
    localparam logic [3:0] ADDR_STATUS_1 = 4'h1;
    localparam logic [3:0] ADDR_COMMAND = 4'h3;
    localparam logic [3:0] ADDR_RX_A_PAIR = 4'hA;
    localparam logic [3:0] ADDR_TX_PAIR = 4'hB;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_TX_READY = 0;
    localparam int BIT_RX_READY = 1;
    localparam int BIT_LINE_MODE_A = 0;
    localparam int BIT_CLOCK_DIR = 1;
    localparam int CMD_WIDTH = 2;
    localparam int WL_LSB = 4;
    localparam int WL_WIDTH = 4;
    localparam int RX_BITS = 12;
    localparam int TX_BITS = 8;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [CMD_WIDTH-1:0] CMD_RESET = 2'h0;
    localparam logic TX_READY_RESET = 1'b1;

    // ----------------------------------------------------------------
    // Synchronised pin vector layout
    // ----------------------------------------------------------------
    localparam int PIN_ALE = 0;
    localparam int PIN_RD_N = 1;
    localparam int PIN_WR_N = 2;
    localparam int PIN_CS_N = 3;
    localparam int PIN_DATA_A = 4;
    localparam int PIN_LIM_LEN_A = 5;
    localparam int PIN_CLK_SHARED = 6;
    localparam int PIN_DATA_B = 7;
    localparam int PIN_LIMIT_B = 8;
    localparam int PIN_LEN_B = 9;
    localparam int PIN_CLK_B = 10;
    localparam int PIN_MODE_B = 11;
    localparam int PIN_BUS_D0 = 12;
    localparam int PIN_COUNT = 20;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLOCK_KHZ = 25000;
    localparam int BIT_CLOCK_HZ = 62500;
    localparam int QUIET_MIN_US = 300;
    localparam int QUIET_MAX_US = 330;
    localparam int MSG_GAP_US = 140;
    localparam int QUIET_MIN_CYC = (QUIET_MIN_US * CLOCK_KHZ + 999) / 1000;
    localparam int QUIET_MAX_CYC = (QUIET_MAX_US * CLOCK_KHZ) / 1000;
    localparam int MSG_GAP_CYC = (MSG_GAP_US * CLOCK_KHZ + 999) / 1000;
    localparam int HALF_BIT_CYC = (CLOCK_KHZ * 1000) / (2 * BIT_CLOCK_HZ);
    localparam int TIMER_WIDTH = 16;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_QUIET = 2'b01,
        TX_SHIFT = 2'b10
    } tx_state_t;

endpackage

// ===== hw/ibus_tx_fifo.sv
// Word FIFO between the holding pair and the transmitter
`timescale 1ns/100ps
module ibus_tx_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic out_valid_q;
    logic [WIDTH-1:0] out_data_q;

    // ------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------
    wire push = in_valid && in_ready;
    wire load = (count_q != '0) && (!out_valid_q || out_ready);
    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = out_valid_q;
    assign out_data = out_data_q;
    assign empty = (count_q == '0) && !out_valid_q;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // Head is prefetched into a register so the read data is a flop
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (load) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
                out_data_q <= mem[rd_ptr_q];
                out_valid_q <= 1'b1;
            end else if (out_ready) begin
                out_valid_q <= 1'b0;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(load);
        end
    end
endmodule

// ===== hw/ibus_serial_rx_tx.sv
// Serial bus receivers A and B, transmitter B and their register port
`timescale 1ns/100ps

module ibus_serial_rx_tx #(
    parameter int QUIET_CYCLES = ibus_pkg::QUIET_MIN_CYC,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic cs_n,
    input wire logic [7:0] bus_data_in,
    output logic [7:0] bus_data_out,
    output logic bus_data_oe,
    input wire logic data_a,
    input wire logic lim_len_a,
    input wire logic clk_shared_in,
    output logic clk_shared_out,
    output logic clk_shared_oe,
    input wire logic data_b_in,
    output logic data_b_out,
    output logic data_b_oe,
    input wire logic bus_limit_clock_in,
    output logic bus_limit_clock_out,
    output logic bus_limit_clock_oe,
    input wire logic bus_length_enable,
    input wire logic clock_b,
    input wire logic rx_b_three_line,
    output logic tx_queue_ready
);
    import ibus_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [PIN_COUNT-1:0] pin_s1_q;
    logic [PIN_COUNT-1:0] pin_s2_q;
    logic [PIN_COUNT-1:0] pin_prev_q;
    wire [PIN_COUNT-1:0] pin_raw = {bus_data_in, rx_b_three_line, clock_b,
        bus_length_enable, bus_limit_clock_in, data_b_in, clk_shared_in,
        lim_len_a, data_a, cs_n, wr_n, rd_n, ale};
    // Idle levels in reset, so no false strobe or edge follows release
    localparam logic [PIN_COUNT-1:0] ONE = PIN_COUNT'(1);
    localparam logic [PIN_COUNT-1:0] PIN_IDLE = (ONE << PIN_RD_N) |
        (ONE << PIN_WR_N) | (ONE << PIN_CS_N) | (ONE << PIN_LIM_LEN_A) |
        (ONE << PIN_CLK_SHARED) | (ONE << PIN_LIMIT_B) | (ONE << PIN_CLK_B);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_s1_q <= PIN_IDLE;
            pin_s2_q <= PIN_IDLE;
            pin_prev_q <= PIN_IDLE;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
        end
    end

    wire [PIN_COUNT-1:0] pin_rise = pin_s2_q & ~pin_prev_q;
    wire [PIN_COUNT-1:0] pin_fall = ~pin_s2_q & pin_prev_q;
    wire [7:0] bus_din = pin_s2_q[PIN_BUS_D0 +: 8];

    // ------------------------------------------------------------
    // Microprocessor register port
    // ------------------------------------------------------------
    logic [3:0] addr_q;
    logic [CMD_WIDTH-1:0] cmd_q;
    logic [7:0] rdata_q;
    logic [7:0] tx_first_q;
    logic wr_second_q;
    logic [1:0] rd_second_q;
    logic tx_ready_q;
    logic [1:0] rx_ready_q;
    logic [RX_BITS+WL_WIDTH-1:0] rx_hold_q [2];

    wire rd_act = !pin_s2_q[PIN_RD_N] && !pin_s2_q[PIN_CS_N];
    wire rd_act_prev = !pin_prev_q[PIN_RD_N] && !pin_prev_q[PIN_CS_N];
    wire wr_act = !pin_s2_q[PIN_WR_N] && !pin_s2_q[PIN_CS_N];
    wire wr_act_prev = !pin_prev_q[PIN_WR_N] && !pin_prev_q[PIN_CS_N];
    wire rd_done = rd_act_prev && !rd_act;
    wire wr_done = wr_act_prev && !wr_act;
    wire wr_tx = wr_done && (addr_q == ADDR_TX_PAIR);
    wire tx_push = wr_tx && wr_second_q;
    wire [1:0] rx_sel = {addr_q == ADDR_TX_PAIR, addr_q == ADDR_RX_A_PAIR};
    wire [1:0] rx_clear = {2{rd_done}} & rx_sel & rd_second_q;
    wire [1:0] rx_set;
    wire [15:0] tx_word;
    wire tx_word_valid;
    wire fifo_empty;
    tx_state_t tx_state_q;

    // Receiver A at index 0, receiver B at index 1
    wire [1:0] pair_ptr = rd_second_q & rx_sel;
    wire rx_idx = rx_sel[1];
    wire [7:0] rx_byte = (|pair_ptr) ? rx_hold_q[rx_idx][15:8] :
        rx_hold_q[rx_idx][7:0];
    wire [7:0] status0 = 8'({rx_ready_q[1], tx_ready_q});
    wire [7:0] status1 = 8'({rx_ready_q[0], 1'b0});
    wire [7:0] rd_mux = (addr_q == ADDR_STATUS_0) ? status0 :
        (addr_q == ADDR_STATUS_1) ? status1 :
        (addr_q == ADDR_COMMAND) ? 8'(cmd_q) :
        (|rx_sel) ? rx_byte : BYTE_ZERO;

    assign bus_data_out = rdata_q;
    assign bus_data_oe = rd_act;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            addr_q <= '0;
            cmd_q <= CMD_RESET;
            rdata_q <= BYTE_ZERO;
            tx_first_q <= BYTE_ZERO;
            wr_second_q <= 1'b0;
            rd_second_q <= '0;
        end else begin
            rdata_q <= rd_mux;
            if (pin_fall[PIN_ALE]) begin
                addr_q <= bus_din[3:0];
            end
            if (wr_done && addr_q == ADDR_COMMAND) begin
                cmd_q <= bus_din[CMD_WIDTH-1:0];
            end
            if (wr_tx) begin
                if (!wr_second_q) begin
                    tx_first_q <= bus_din;
                end
                wr_second_q <= !wr_second_q;
            end
            if (rd_done) begin
                rd_second_q <= rd_second_q ^ rx_sel;
            end
        end
    end

    // Ready flags: receiver set wins over a same-cycle read clear; a pair write clear beats the transmitter set
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tx_ready_q <= TX_READY_RESET;
            rx_ready_q <= '0;
        end else begin
            rx_ready_q <= rx_set | (rx_ready_q & ~rx_clear);
            if (tx_push) begin
                tx_ready_q <= 1'b0;
            end else if (tx_state_q == TX_IDLE && fifo_empty) begin
                tx_ready_q <= 1'b1;
            end
        end
    end

    AST_TXRDY_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
        tx_push |=> !tx_ready_q ##1 !tx_ready_q)
        else $error("transmitter ready not cleared by pair write");
    AST_PAIR_ORDER: assert property (@(posedge clock) disable iff (!resetn)
        wr_tx && !wr_second_q |=> wr_second_q && $stable(tx_ready_q))
        else $error("first holding byte started a transfer");

    // ------------------------------------------------------------
    // Bit clock divider and shared clock pin
    // ------------------------------------------------------------
    logic [TIMER_WIDTH-1:0] div_q;
    logic div_clk_q;
    wire div_tick = (div_q == TIMER_WIDTH'(HALF_BIT_CYC - 1));
    wire clk_out_mode = cmd_q[BIT_CLOCK_DIR];
    // Input role: transmitter steps on each edge of the shared pin
    wire ext_tick = pin_rise[PIN_CLK_SHARED] || pin_fall[PIN_CLK_SHARED];
    wire bit_tick = clk_out_mode ? div_tick : ext_tick;

    assign clk_shared_out = div_clk_q;
    assign clk_shared_oe = clk_out_mode;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            div_q <= '0;
            div_clk_q <= 1'b1;
        end else begin
            div_q <= div_tick ? '0 : div_q + 1'b1;
            if (div_tick) begin
                div_clk_q <= !div_clk_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmitter B
    // ------------------------------------------------------------
    logic [TIMER_WIDTH-1:0] quiet_q;
    logic [15:0] tx_next_q;
    logic [2:0] tx_echo_q;
    logic [TX_BITS-1:0] tx_shift_q;
    logic [WL_WIDTH-1:0] tx_bits_q;
    logic tx_phase_q;
    logic tx_lim_q;
    logic tx_dout_q;
    wire line_pulse = pin_fall[PIN_LIMIT_B];
    wire quiet_done = (quiet_q == TIMER_WIDTH'(QUIET_CYCLES - 1));
    wire [WL_WIDTH-1:0] tx_len = tx_next_q[15-:WL_WIDTH];
    wire tx_take = (tx_state_q == TX_IDLE);
    wire shifting = (tx_state_q == TX_SHIFT);

    assign data_b_out = tx_dout_q;
    assign data_b_oe = shifting;
    assign bus_limit_clock_out = tx_lim_q;
    assign bus_limit_clock_oe = shifting;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tx_state_q <= TX_IDLE;
            quiet_q <= '0;
            tx_shift_q <= '0;
            tx_bits_q <= '0;
            tx_phase_q <= 1'b0;
            tx_lim_q <= 1'b1;
            tx_dout_q <= 1'b0;
            tx_next_q <= '0;
            tx_echo_q <= '0;
        end else begin
            tx_echo_q <= {tx_echo_q[1:0], shifting};
            unique case (tx_state_q)
                TX_IDLE: begin
                    quiet_q <= '0;
                    // The queue head moves on once taken, so keep a copy
                    tx_next_q <= tx_word;
                    if (tx_word_valid) begin
                        tx_state_q <= TX_QUIET;
                    end
                end
                TX_QUIET: begin
                    if (line_pulse) begin
                        quiet_q <= '0;
                    end else if (quiet_done) begin
                        tx_shift_q <= tx_next_q[7:0];
                        tx_bits_q <= tx_len;
                        tx_dout_q <= tx_next_q[0];
                        tx_lim_q <= (tx_len == '0);
                        tx_phase_q <= 1'b1;
                        tx_state_q <= (tx_len == '0) ? TX_IDLE : TX_SHIFT;
                    end else begin
                        quiet_q <= quiet_q + 1'b1;
                    end
                end
                TX_SHIFT: begin
                    if (bit_tick && tx_phase_q) begin
                        tx_lim_q <= 1'b1;
                        tx_shift_q <= tx_shift_q >> 1;
                        tx_bits_q <= tx_bits_q - 1'b1;
                        tx_phase_q <= 1'b0;
                        if (tx_bits_q == WL_WIDTH'(1)) begin
                            tx_state_q <= TX_IDLE;
                        end
                    end else if (bit_tick) begin
                        tx_lim_q <= 1'b0;
                        tx_dout_q <= tx_shift_q[0];
                        tx_phase_q <= 1'b1;
                    end
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    ibus_tx_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clock(clock),
        .resetn(resetn),
        .in_valid(tx_push),
        .in_ready(tx_queue_ready),
        .in_data({bus_din, tx_first_q}),
        .out_valid(tx_word_valid),
        .out_ready(tx_take),
        .out_data(tx_word),
        .empty(fifo_empty)
    );

    AST_QUIET_RESTART: assert property (@(posedge clock) disable iff (!resetn)
        tx_state_q == TX_QUIET && line_pulse |=> quiet_q == '0)
        else $error("limit clock pulse did not restart the timeout");
    AST_LOAD_COUNT: assert property (@(posedge clock) disable iff (!resetn)
        tx_state_q == TX_QUIET && !line_pulse && quiet_done && tx_len != '0
        |=> shifting && tx_bits_q == $past(tx_len))
        else $error("shifter not loaded at timeout end");
    AST_FIRST_EDGE: assert property (@(posedge clock) disable iff (!resetn)
        $rose(shifting) |-> !tx_lim_q && $past(quiet_q) >= (QUIET_CYCLES - 1)
        && $past(quiet_q) <
        QUIET_CYCLES + QUIET_MAX_CYC - QUIET_MIN_CYC)
        else $error("first edge outside the quiet window");
    AST_BIT_COUNT: assert property (@(posedge clock) disable iff (!resetn)
        $fell(shifting) |-> tx_bits_q == '0 && tx_lim_q)
        else $error("transfer ended before all bits were clocked");

    // ------------------------------------------------------------
    // Receivers A (index 0) and B (index 1)
    // ------------------------------------------------------------
    wire [1:0] three_line = {pin_s2_q[PIN_MODE_B], cmd_q[BIT_LINE_MODE_A]};
    wire [1:0] rx_data = {pin_s2_q[PIN_DATA_B], pin_s2_q[PIN_DATA_A]};
    wire [1:0] en_lvl = {pin_s2_q[PIN_LEN_B], pin_s2_q[PIN_LIM_LEN_A]};
    wire [1:0] lim_rise = {pin_rise[PIN_LIMIT_B], pin_rise[PIN_LIM_LEN_A]};
    wire [1:0] en_fall = {pin_fall[PIN_LEN_B], pin_fall[PIN_LIM_LEN_A]};
    // Receiver A borrows the shared pin as its three-line clock
    wire [1:0] clk3_rise = {pin_rise[PIN_CLK_B],
        pin_rise[PIN_CLK_SHARED] && !clk_out_mode};
    // Receiver B ignores our own frame, plus the synchroniser delay
    wire [1:0] rx_block = {shifting || (|tx_echo_q), 1'b0};

    for (genvar g = 0; g < 2; g++) begin : g_rx
        logic [RX_BITS-1:0] sr_q;
        logic [WL_WIDTH-1:0] len_q;
        logic [TIMER_WIDTH-1:0] gap_q;
        wire shift_in = !rx_block[g] && (three_line[g] ?
            (clk3_rise[g] && en_lvl[g]) : lim_rise[g]);
        wire gap_end = !three_line[g] &&
            gap_q == TIMER_WIDTH'(MSG_GAP_CYC - 1);
        wire msg_end = (len_q != '0) && !shift_in &&
            (three_line[g] ? en_fall[g] : gap_end);
        assign rx_set[g] = msg_end && !rx_ready_q[g];

        always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
                sr_q <= '0;
                len_q <= '0;
                gap_q <= '0;
                rx_hold_q[g] <= '0;
            end else begin
                gap_q <= shift_in ? '0 : gap_q + TIMER_WIDTH'(!gap_end);
                if (shift_in) begin
                    sr_q <= {rx_data[g], sr_q[RX_BITS-1:1]};
                    len_q <= len_q + WL_WIDTH'(len_q != '1);
                end else if (msg_end) begin
                    len_q <= '0;
                end
                if (rx_set[g]) begin
                    rx_hold_q[g] <= {len_q, sr_q};
                end
            end
        end

        AST_RX_SET: assert property (@(posedge clock) disable iff (!resetn)
            msg_end && !rx_ready_q[g] |=> rx_ready_q[g])
            else $error("receiver ready not set after message");
        AST_RX_KEEP: assert property (@(posedge clock) disable iff (!resetn)
            rx_ready_q[g] && !rx_clear[g] |=> $stable(rx_hold_q[g]))
            else $error("held message overwritten while ready");
        AST_RX_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
            rx_clear[g] && !rx_set[g] |=> !rx_ready_q[g])
            else $error("pair read did not clear receiver ready");
    end
endmodule

// ===== test/ibus_station.sv
// Far-side bus station: feeds receivers A and B, samples transmitter B
`timescale 1ns/100ps
module ibus_station (
    input wire logic data_b_out,
    input wire logic data_b_oe,
    input wire logic bus_limit_clock_out,
    input wire logic bus_limit_clock_oe,
    output logic data_a,
    output logic lim_len_a,
    output logic clk_shared_in,
    output logic data_b_in,
    output logic bus_limit_clock_in,
    output logic bus_length_enable,
    output logic clock_b
);
    // ----------------------------------------------------------------
    // Line model
    // ----------------------------------------------------------------
    logic p_dat, p_lim, stall, clk_run, drv, d_hold;
    logic [15:0] cap;
    int cap_n, frames;
    time t_last;
    // Open-drain lines with pull-ups, so a released line reads high
    assign data_b_in = (data_b_oe ? data_b_out : 1'b1) & p_dat;
    assign bus_limit_clock_in =
        (bus_limit_clock_oe ? bus_limit_clock_out : 1'b1) & p_lim;
    initial begin
        {data_a, lim_len_a, clk_shared_in, p_dat, p_lim, clock_b} = 6'h3F;
        {bus_length_enable, stall, clk_run, drv} = 4'h0;
        cap = '0;
        cap_n = 0;
        frames = 0;
        t_last = 0;
    end
    // Clock runs only while a frame is wanted, never free
    always #160 if (clk_run) clk_shared_in = ~clk_shared_in;
    // Busy bus: keeps pulsing the limit clock
    always @(posedge stall) begin
        while (stall) begin
            p_lim = 1'b0;
            t_last = $time;
            #160 p_lim = 1'b1;
            #160;
        end
    end
    // Data settles as the line falls; the last rise ends the frame
    always @(negedge bus_limit_clock_in) begin
        #1;
        drv = data_b_oe;
        d_hold = data_b_out;
    end
    always @(posedge bus_limit_clock_in) begin
        if (drv) begin
            cap[cap_n] = d_hold;
            cap_n++;
        end
        drv = 1'b0;
    end
    always @(posedge data_b_oe) frames++;
    task automatic pin(input bit b, input bit t, input logic v);
        if (t && b) clock_b = v;
        else if (t) clk_shared_in = v;
        else if (b) p_lim = v;
        else lim_len_a = v;
    endtask
    task automatic send(input bit b, input bit t, input logic [11:0] m);
        if (t && b) bus_length_enable = 1'b1;
        else if (t) lim_len_a = 1'b1;
        for (int i = 0; i < 12; i++) begin
            if (b) p_dat = m[i];
            else data_a = m[i];
            pin(b, t, 1'b0);
            #160 pin(b, t, 1'b1);
            #160;
        end
        if (t && b) bus_length_enable = 1'b0;
        else if (t) lim_len_a = 1'b0;
        p_dat = 1'b1;
        data_a = 1'b1;
    endtask
endmodule

// ===== test/tb.sv
// Self-checking bench for the serial bus unit
`timescale 1ns/100ps
module tb;
    import ibus_pkg::*;
    // Shortened quiet period keeps the run short
    localparam int QUIET = 300;
    localparam int DEPTH = 16;
    typedef struct packed {
        logic [2:0] kind;
        logic [7:0] a;
        logic [11:0] m;
    } row_t;
    // Kind 0 sends a pair; kind 4 receives, plus 1 for B, plus 2 three-line
    row_t rows [8] = '{
        '{3'h0, 8'hA5, 12'h008}, '{3'h0, 8'h3C, 12'h003},
        '{3'h0, 8'hFF, 12'h00A}, '{3'h0, 8'h81, 12'h001},
        '{3'h5, 8'h00, 12'hA5C}, '{3'h7, 8'h00, 12'h3E1},
        '{3'h4, 8'h00, 12'h96B}, '{3'h6, 8'h00, 12'h5D2}
    };
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic ale = 1'b0;
    logic rd_n = 1'b1, wr_n = 1'b1, cs_n = 1'b1;
    logic rx_b_three_line = 1'b0;
    logic [7:0] host_d = 8'h00;
    logic [7:0] bus_data_in, bus_data_out, d, d2;
    logic bus_data_oe, clk_shared_out, clk_shared_oe, data_b_out, data_b_oe;
    logic bus_limit_clock_out, bus_limit_clock_oe, tx_queue_ready, prev;
    logic data_a, lim_len_a, clk_shared_in, data_b_in, bus_limit_clock_in;
    logic bus_length_enable, clock_b;
    int num_errors = 0;
    int compares = 0;
    int k, n, f0;
    longint cyc;
    assign bus_data_in = bus_data_oe ? bus_data_out : host_d;
    always #20 clock = ~clock;
    ibus_serial_rx_tx #(.QUIET_CYCLES(QUIET), .FIFO_DEPTH(DEPTH)) DUT (
        .clock, .resetn, .ale, .rd_n, .wr_n, .cs_n, .bus_data_in,
        .bus_data_out, .bus_data_oe, .data_a, .lim_len_a, .clk_shared_in,
        .clk_shared_out, .clk_shared_oe, .data_b_in, .data_b_out,
        .data_b_oe, .bus_limit_clock_in, .bus_limit_clock_out,
        .bus_limit_clock_oe, .bus_length_enable, .clock_b,
        .rx_b_three_line, .tx_queue_ready
    );
    ibus_station p (
        .data_b_out, .data_b_oe, .bus_limit_clock_out, .bus_limit_clock_oe,
        .data_a, .lim_len_a, .clk_shared_in, .data_b_in,
        .bus_limit_clock_in, .bus_length_enable, .clock_b
    );
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic step(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task conclude();
        $display("compares %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic addr(input logic [3:0] a);
        host_d = {4'h0, a};
        ale = 1'b1;
        step(4);
        ale = 1'b0;
        step(4);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        addr(a);
        host_d = v;
        {cs_n, wr_n} = 2'b00;
        step(5);
        {cs_n, wr_n} = 2'b11;
        step(5);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        addr(a);
        {cs_n, rd_n} = 2'b00;
        step(6);
        v = bus_data_out;
        {cs_n, rd_n} = 2'b11;
        step(6);
    endtask
    task automatic tx_row(input row_t r);
        logic [15:0] e;
        e = {8'h00, r.a} & ((16'h0001 << r.m[3:0]) - 16'h0001);
        p.cap = '0;
        p.cap_n = 0;
        f0 = p.frames;
        wr(ADDR_TX_PAIR, r.a);
        wr(ADDR_TX_PAIR, {r.m[3:0], 4'h0});
        rd(ADDR_STATUS_0, d);
        chk("tx ready", 16'h0000, 16'(d[BIT_TX_READY]));
        p.clk_run = 1'b1;
        k = 0;
        while ((p.frames == f0 || data_b_oe !== 1'b0) && k < 3000) begin
            step(1);
            k++;
        end
        p.clk_run = 1'b0;
        step(4);
        rd(ADDR_STATUS_0, d);
        chk("tx ready", 16'h0001, 16'(d[BIT_TX_READY]));
        chk("tx bits", e, p.cap);
        chk("tx count", 16'(r.m[3:0]), 16'(p.cap_n));
    endtask
    task automatic rx_row(input row_t r);
        logic b, t;
        logic [3:0] st, pr;
        b = r.kind[0];
        t = r.kind[1];
        st = b ? ADDR_STATUS_0 : ADDR_STATUS_1;
        pr = b ? ADDR_TX_PAIR : ADDR_RX_A_PAIR;
        rx_b_three_line = b & t;
        if (!b && t) begin
            p.lim_len_a = 1'b0;
            wr(ADDR_COMMAND, 8'h01);
        end
        p.send(b, t, r.m);
        step(3600);
        rd(st, d);
        chk("rx ready", 16'h0001, 16'(d[BIT_RX_READY]));
        p.send(b, t, ~r.m);
        step(3600);
        rd(pr, d);
        rd(pr, d2);
        chk("rx pair", {4'hC, r.m}, {d2, d});
        rd(st, d);
        chk("rx ready", 16'h0000, 16'(d[BIT_RX_READY]));
    endtask
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        step(2);
        chk("reset pins", 16'h0021, 16'({clk_shared_out, clk_shared_oe,
            data_b_oe, bus_limit_clock_oe, bus_data_oe, tx_queue_ready}));
        step(8);
        resetn = 1'b1;
        step(2);
        rd(ADDR_STATUS_0, d);
        chk("status 0", 16'h0001, 16'(d));
        rd(ADDR_STATUS_1, d);
        chk("status 1", 16'h0000, 16'(d));
        $display("test reset done");
        wr(ADDR_COMMAND, 8'hFE);
        rd(ADDR_COMMAND, d);
        chk("command", 16'h0002, 16'(d));
        chk("clock pin oe", 16'h0001, 16'(clk_shared_oe));
        k = 0;
        prev = clk_shared_out;
        repeat (800) begin
            step(1);
            if (clk_shared_out !== prev) k++;
            prev = clk_shared_out;
        end
        chk("clock pin toggles", 16'h0004, 16'(k));
        wr(ADDR_COMMAND, 8'h00);
        chk("clock pin oe", 16'h0000, 16'(clk_shared_oe));
        wr(4'h5, 8'h5A);
        rd(4'h5, d);
        chk("unmapped", 16'h0000, 16'(d));
        $display("test registers done");
        foreach (rows[i]) begin
            if (rows[i].kind[2]) rx_row(rows[i]);
            else tx_row(rows[i]);
            $display("test row %0d done", i);
        end
        // Busy bus holds every word in the queue until it refuses
        p.stall = 1'b1;
        step(20);
        n = 0;
        while (tx_queue_ready === 1'b1 && n < 20) begin
            wr(ADDR_TX_PAIR, 8'h01);
            wr(ADDR_TX_PAIR, 8'h10);
            n++;
        end
        chk("queue accepted", 16'(DEPTH + 2), 16'(n));
        wr(ADDR_TX_PAIR, 8'h01);
        wr(ADDR_TX_PAIR, 8'h10);
        f0 = p.frames;
        p.stall = 1'b0;
        k = 0;
        while (data_b_oe !== 1'b1 && k < 2000) begin
            step(1);
            k++;
        end
        cyc = ($time - p.t_last) / 40;
        chk("quiet span", 16'h0001,
            16'(cyc >= QUIET && cyc <= QUIET + 6));
        p.clk_run = 1'b1;
        while ((p.frames - f0 < n || data_b_oe !== 1'b0) && k < 12000) begin
            step(1);
            k++;
        end
        p.clk_run = 1'b0;
        step(4);
        chk("frames sent", 16'(n), 16'(p.frames - f0));
        chk("queue ready", 16'h0001, 16'(tx_queue_ready));
        rd(ADDR_STATUS_0, d);
        chk("tx ready", 16'h0001, 16'(d[BIT_TX_READY]));
        $display("test queue done");
        conclude();
    end
    initial begin
        #3000000;
        num_errors++;
        $display("watchdog expired");
        conclude();
    end
endmodule
